// [core/sleep_wake_pkg.sv]
// Purpose: Shared constants and types for the sleep and wake controller.
// Assumes: 100 MHz pclk, APB register port with 32-bit data.
// Notes:   Times are kept in their own units; cycle counts derive from them.
package sleep_wake_pkg;

	// Clock and time base
	localparam int unsigned CLK_PERIOD_NS    = 10;
	localparam int unsigned MS_NS            = 1000000;
	localparam int unsigned MS_CYCLES        = MS_NS / CLK_PERIOD_NS;
	localparam int unsigned SLEEP_UNIT_MS    = 10;
	// Pending message held for 2.5 sleep units, in ms per unit
	localparam int unsigned HOLD_MS_PER_UNIT = (SLEEP_UNIT_MS * 5) / 2;
	localparam int unsigned BRIEF_WAKE_MS    = 10;

	// Field widths
	localparam int unsigned MODE_W  = 3;
	localparam int unsigned OPT_W   = 16;
	localparam int unsigned CNT_W   = 16;
	localparam int unsigned SLEEP_W = 21;
	localparam int unsigned WAKE_W  = 22;
	localparam int unsigned HOST_W  = 16;
	localparam int unsigned HOLD_W  = 26;

	// Register byte offsets
	localparam logic [7:0] MODE_OFS   = 8'h00;
	localparam logic [7:0] OPT_OFS    = 8'h04;
	localparam logic [7:0] CYCLE_OFS  = 8'h08;
	localparam logic [7:0] SLEEP_OFS  = 8'h0C;
	localparam logic [7:0] WAKE_OFS   = 8'h10;
	localparam logic [7:0] HOST_OFS   = 8'h14;
	localparam logic [7:0] CTRL_OFS   = 8'h18;
	localparam logic [7:0] STATUS_OFS = 8'h1C;

	// Mode codes
	localparam logic [MODE_W-1:0] MODE_NONE      = 3'h0;
	localparam logic [MODE_W-1:0] MODE_PIN       = 3'h1;
	localparam logic [MODE_W-1:0] MODE_CYCLIC    = 3'h4;
	localparam logic [MODE_W-1:0] MODE_CYCLIC_PW = 3'h5;

	// Legal values and limits
	localparam logic [OPT_W-1:0]   OPT_FULL_WAKE = 16'h0100;
	localparam int unsigned        OPT_FULL_BIT  = 8;
	localparam logic [CNT_W-1:0]   CYCLE_MIN     = 16'h0001;
	localparam logic [SLEEP_W-1:0] SLEEP_MIN     = 21'h000001;
	localparam logic [SLEEP_W-1:0] SLEEP_MAX     = 21'h15F900;
	localparam logic [WAKE_W-1:0]  WAKE_MIN      = 22'h000001;
	localparam logic [WAKE_W-1:0]  WAKE_MAX      = 22'h36EE80;

	// Values after reset
	localparam logic [MODE_W-1:0]  MODE_RST  = 3'h0;
	localparam logic [OPT_W-1:0]   OPT_RST   = 16'h0000;
	localparam logic [CNT_W-1:0]   CYCLE_RST = 16'h0001;
	localparam logic [SLEEP_W-1:0] SLEEP_RST = 21'h0000C8;
	localparam logic [WAKE_W-1:0]  WAKE_RST  = 22'h0007D0;
	localparam logic [HOST_W-1:0]  HOST_RST  = 16'h0000;

	typedef enum logic [1:0] {
		S_ON,
		S_WINDOW,
		S_ASLEEP
	} power_state_t;

	typedef struct packed {
		logic [MODE_W-1:0]  sleep_mode_select;
		logic [OPT_W-1:0]   options;
		logic [CNT_W-1:0]   status_assert_cycle_count;
		logic [SLEEP_W-1:0] sleep_period;
		logic [WAKE_W-1:0]  wake_period;
		logic [HOST_W-1:0]  host_wake_delay;
		logic               coord_enable;
	} config_t;

endpackage : sleep_wake_pkg

// [core/tick_timer.sv]
// Purpose: Down counter that runs on a tick enable and pulses when it ends.
// Assumes: Single pclk domain, tick is a one-cycle enable.
// Notes:   First tick may come early, so the time is short by under a tick.
module tick_timer #(
	parameter int unsigned W = 16
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic         load,
	input  wire logic [W-1:0] value,
	input  wire logic         stop,
	input  wire logic         tick,
	output logic              busy,
	output logic              done
);

	logic [W-1:0] count_reg;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			count_reg <= '0;
			busy      <= 1'b0;
			done      <= 1'b0;
		end
		else
		begin
			done <= 1'b0;
			if (load)
			begin
				count_reg <= value;
				busy      <= (value != '0);
			end
			else if (stop)
				busy <= 1'b0;
			else if (busy && tick)
			begin
				count_reg <= count_reg - W'(1);
				if (count_reg == W'(1))
				begin
					busy <= 1'b0;
					done <= 1'b1;
				end
			end
		end
	end

endmodule : tick_timer

// [core/sleep_wake_controller.sv]
// Purpose: Sleep and wake sequencer with APB configuration registers.
// Assumes: All inputs synchronous to pclk; activity inputs are pulses.
// Notes:   Timers run on a 1 ms enable; sleep time counts 10 ms enables.
// Functional notes
// - Modes 0 none, 1 pin, 4/5 cyclic.
// - Pin modes: releasing sleep request wakes device.
// - Cyclic: sleep period, brief check, then sleep.
// - No synchronous sleep mode exists.
// - Options accept 0x0000 or 0x0100; bit8 full wake.
// - Status asserts every Nth cyclic wakeup, N default 1.
// - Sleep period is setting times 10 ms.
// - Coordinator holds pending message 2.5 sleep periods.
// - Cyclic: activity keeps device awake for wake period.
// - Host-wake delay gates output after waking.
// - Zero host-wake delay means no delay.
// - Host serial character ends host-wake delay.
module sleep_wake_controller
	import sleep_wake_pkg::*;
#(
	parameter int unsigned MS_TICK_CYCLES = MS_CYCLES,
	parameter int unsigned BRIEF_MS       = BRIEF_WAKE_MS
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        sleep_request,
	input  wire logic        rf_activity,
	input  wire logic        serial_rx_char,
	input  wire logic        msg_queued,
	input  wire logic        msg_delivered,
	output logic             sleep_status,
	output logic             awake,
	output logic             host_tx_hold,
	output logic             msg_pending,
	output logic             msg_discard
);

	config_t      cfg_reg;
	power_state_t state_reg;
	power_state_t state_next;
	logic [CNT_W-1:0] wake_cnt_reg;
	logic [CNT_W-1:0] wake_cnt_next;
	logic         assert_on_reg;
	logic         assert_on_next;
	logic         status_reg;
	logic         awake_reg;
	logic [31:0]  prdata_reg;
	logic [16:0]  div_reg;
	logic         ms_tick;
	logic [3:0]   unit_reg;
	logic         unit_tick;
	logic         unit_restart;

	// Time base: 1 ms enable and 10 ms enable
	assign ms_tick   = (div_reg == 17'(MS_TICK_CYCLES - 1));
	assign unit_tick = ms_tick && (unit_reg == 4'(SLEEP_UNIT_MS - 1));

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			div_reg  <= 17'h00000;
			unit_reg <= 4'h0;
		end
		else
		begin
			div_reg <= ms_tick ? 17'h00000 : div_reg + 17'h00001;
			// Restart the 10 ms count at sleep entry so a sleep is short by under 1 ms
			if (unit_restart)
				unit_reg <= 4'h0;
			else if (ms_tick)
				unit_reg <= unit_tick ? 4'h0 : unit_reg + 4'h1;
		end
	end

	// APB decode
	wire setup_phase = psel && !penable;
	wire wr_access   = psel && penable && pwrite;
	wire hit_mode    = (paddr == MODE_OFS);
	wire hit_opt     = (paddr == OPT_OFS);
	wire hit_cycle   = (paddr == CYCLE_OFS);
	wire hit_sleep   = (paddr == SLEEP_OFS);
	wire hit_wake    = (paddr == WAKE_OFS);
	wire hit_host    = (paddr == HOST_OFS);
	wire hit_ctrl    = (paddr == CTRL_OFS);
	wire hit_status  = (paddr == STATUS_OFS);
	wire mapped      = hit_mode || hit_opt || hit_cycle || hit_sleep || hit_wake
		|| hit_host || hit_ctrl || hit_status;

	// Value checks; a rejected write leaves the register unchanged
	wire [MODE_W-1:0] wr_mode = pwdata[MODE_W-1:0];
	wire mode_ok  = (pwdata[31:MODE_W] == '0) && (wr_mode == MODE_NONE
		|| wr_mode == MODE_PIN || wr_mode == MODE_CYCLIC
		|| wr_mode == MODE_CYCLIC_PW);
	wire opt_ok   = (pwdata == 32'h00000000)
		|| (pwdata == {16'h0000, OPT_FULL_WAKE});
	wire cycle_ok = (pwdata[31:CNT_W] == '0) && (pwdata[CNT_W-1:0] >= CYCLE_MIN);
	wire sleep_ok = (pwdata[31:SLEEP_W] == '0) && (pwdata[SLEEP_W-1:0] >= SLEEP_MIN)
		&& (pwdata[SLEEP_W-1:0] <= SLEEP_MAX);
	wire wake_ok  = (pwdata[31:WAKE_W] == '0) && (pwdata[WAKE_W-1:0] >= WAKE_MIN)
		&& (pwdata[WAKE_W-1:0] <= WAKE_MAX);
	wire host_ok  = (pwdata[31:HOST_W] == '0);
	wire wr_bad   = (hit_mode && !mode_ok) || (hit_opt && !opt_ok)
		|| (hit_cycle && !cycle_ok) || (hit_sleep && !sleep_ok)
		|| (hit_wake && !wake_ok) || (hit_host && !host_ok) || hit_status;

	assign pready  = 1'b1;
	assign pslverr = psel && penable && (!mapped || (pwrite && wr_bad));
	assign prdata  = prdata_reg;

	// Timers
	logic wake_busy;
	logic wake_done;
	logic sleep_busy;
	logic sleep_done;
	logic host_busy;
	logic hold_done;

	wire hold_busy_w;
	wire cyclic     = (cfg_reg.sleep_mode_select == MODE_CYCLIC)
		|| (cfg_reg.sleep_mode_select == MODE_CYCLIC_PW);
	wire pin_wake   = (cfg_reg.sleep_mode_select == MODE_CYCLIC_PW) && !sleep_request;
	wire activity   = rf_activity || serial_rx_char;
	wire full_wake  = cfg_reg.options[OPT_FULL_BIT];

	wire [31:0] status_word = {24'h000000, 1'b0, hold_busy_w, host_busy, status_reg,
		awake_reg, 1'b0, state_reg};
	wire [31:0] rd_word =
		hit_mode   ? 32'(cfg_reg.sleep_mode_select) :
		hit_opt    ? 32'(cfg_reg.options) :
		hit_cycle  ? 32'(cfg_reg.status_assert_cycle_count) :
		hit_sleep  ? 32'(cfg_reg.sleep_period) :
		hit_wake   ? 32'(cfg_reg.wake_period) :
		hit_host   ? 32'(cfg_reg.host_wake_delay) :
		hit_ctrl   ? 32'(cfg_reg.coord_enable) :
		hit_status ? status_word : 32'h00000000;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cfg_reg    <= '{MODE_RST, OPT_RST, CYCLE_RST, SLEEP_RST, WAKE_RST,
				HOST_RST, 1'b0};
			prdata_reg <= 32'h00000000;
		end
		else
		begin
			if (setup_phase)
				prdata_reg <= rd_word;
			if (wr_access && !wr_bad)
			begin
				if (hit_mode)
					cfg_reg.sleep_mode_select <= wr_mode;
				if (hit_opt)
					cfg_reg.options <= pwdata[OPT_W-1:0];
				if (hit_cycle)
					cfg_reg.status_assert_cycle_count <= pwdata[CNT_W-1:0];
				if (hit_sleep)
					cfg_reg.sleep_period <= pwdata[SLEEP_W-1:0];
				if (hit_wake)
					cfg_reg.wake_period <= pwdata[WAKE_W-1:0];
				if (hit_host)
					cfg_reg.host_wake_delay <= pwdata[HOST_W-1:0];
				if (hit_ctrl)
					cfg_reg.coord_enable <= pwdata[0];
			end
		end
	end

	// Power state sequencing
	always_comb
	begin
		state_next = state_reg;
		unique case (cfg_reg.sleep_mode_select)
			MODE_PIN:
				state_next = sleep_request ? S_ASLEEP : S_ON;
			MODE_CYCLIC, MODE_CYCLIC_PW:
				unique case (state_reg)
					S_ON:
						state_next = S_WINDOW;
					S_WINDOW:
						// Pin-held wake keeps the window open in mode 5
						if (wake_done && !activity && !pin_wake)
							state_next = S_ASLEEP;
					S_ASLEEP:
						if (sleep_done || pin_wake)
							state_next = S_WINDOW;
				endcase
			default:
				state_next = S_ON;
		endcase
	end

	wire wake_evt  = (state_reg == S_ASLEEP) && (state_next != S_ASLEEP);
	wire sleep_evt = (state_reg != S_ASLEEP) && (state_next == S_ASLEEP);
	assign unit_restart = sleep_evt && cyclic;
	wire cyc_wake  = wake_evt && cyclic && !pin_wake;
	wire [CNT_W-1:0] cnt_inc = wake_cnt_reg + CNT_W'(1);

	// Count cyclic wakeups; only the Nth, or a pin wake in mode 5, raises the status line
	always_comb
	begin
		wake_cnt_next  = wake_cnt_reg;
		assert_on_next = assert_on_reg;
		if (!cyclic || state_reg == S_ON || (wake_evt && pin_wake))
		begin
			wake_cnt_next  = '0;
			assert_on_next = 1'b1;
		end
		else if (cyc_wake)
		begin
			if (cnt_inc >= cfg_reg.status_assert_cycle_count)
			begin
				wake_cnt_next  = '0;
				assert_on_next = 1'b1;
			end
			else
			begin
				wake_cnt_next  = cnt_inc;
				assert_on_next = 1'b0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_reg     <= S_ON;
			wake_cnt_reg  <= '0;
			assert_on_reg <= 1'b1;
			status_reg    <= 1'b1;
			awake_reg     <= 1'b1;
		end
		else
		begin
			state_reg     <= state_next;
			wake_cnt_reg  <= wake_cnt_next;
			assert_on_reg <= assert_on_next;
			status_reg    <= (state_next != S_ASLEEP) && assert_on_next;
			awake_reg     <= (state_next != S_ASLEEP);
		end
	end

	assign sleep_status = status_reg;
	assign awake        = awake_reg;

	// Window length: brief check after sleep unless full wake is forced or activity seen
	wire window_start = (state_reg == S_ON) && (state_next == S_WINDOW);
	wire wake_load    = window_start || (state_next == S_WINDOW && activity)
		|| (wake_evt && cyclic);
	wire [WAKE_W-1:0] wake_value = (wake_evt && !activity && !full_wake)
		? WAKE_W'(BRIEF_MS) : cfg_reg.wake_period;

	tick_timer #(.W(WAKE_W)) wake_timer (
		.pclk    (pclk),
		.presetn (presetn),
		.load    (wake_load),
		.value   (wake_value),
		.stop    (state_next != S_WINDOW),
		.tick    (ms_tick),
		.busy    (wake_busy),
		.done    (wake_done)
	);

	tick_timer #(.W(SLEEP_W)) sleep_timer (
		.pclk    (pclk),
		.presetn (presetn),
		.load    (sleep_evt && cyclic),
		.value   (cfg_reg.sleep_period),
		.stop    (state_next != S_ASLEEP),
		.tick    (unit_tick),
		.busy    (sleep_busy),
		.done    (sleep_done)
	);

	// Host-wake delay; a zero setting never starts the timer
	tick_timer #(.W(HOST_W)) host_timer (
		.pclk    (pclk),
		.presetn (presetn),
		.load    (wake_evt),
		.value   (cfg_reg.host_wake_delay),
		.stop    (serial_rx_char || state_next == S_ASLEEP),
		.tick    (ms_tick),
		.busy    (host_busy),
		.done    ()
	);

	assign host_tx_hold = host_busy || !awake_reg;

	// Indirect message hold: 2.5 sleep periods in ms
	wire [HOLD_W-1:0] hold_value = HOLD_W'(cfg_reg.sleep_period) * HOLD_W'(HOLD_MS_PER_UNIT);

	tick_timer #(.W(HOLD_W)) hold_timer (
		.pclk    (pclk),
		.presetn (presetn),
		.load    (msg_queued && cfg_reg.coord_enable),
		.value   (hold_value),
		.stop    (msg_delivered || !cfg_reg.coord_enable),
		.tick    (ms_tick),
		.busy    (hold_busy_w),
		.done    (hold_done)
	);

	assign msg_pending = hold_busy_w;
	assign msg_discard = hold_done;

endmodule : sleep_wake_controller

// [dv/sleep_wake_props.sv]
// Purpose: Port-level checks for the sleep and wake controller.
// Assumes: One pclk domain; mode is tracked from accepted APB writes.
// Notes:   Mode shadow trusts pslverr, so the code check guards it.
module sleep_wake_props
	import sleep_wake_pkg::*;
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        sleep_request,
	input wire logic        rf_activity,
	input wire logic        serial_rx_char,
	input wire logic        msg_queued,
	input wire logic        msg_delivered,
	input wire logic        sleep_status,
	input wire logic        awake,
	input wire logic        host_tx_hold,
	input wire logic        msg_pending,
	input wire logic        msg_discard
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [2:0] mode_q;
	wire        wr = psel && penable && pwrite;
	wire        wr_mode = wr && paddr == MODE_OFS && !pslverr;
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			mode_q <= 3'h0;
		else if (wr_mode)
			mode_q <= pwdata[2:0];
	mode_code_a: assert property (wr && paddr == MODE_OFS
		&& !(pwdata inside {32'h0, 32'h1, 32'h4, 32'h5}) |-> pslverr) else $error("Bad mode taken");
	opt_value_a: assert property (wr && paddr == OPT_OFS
		|-> pslverr == !(pwdata inside {32'h0, 32'h100})) else $error("Options check wrong");
	cycle_range_a: assert property (wr && paddr == CYCLE_OFS
		|-> pslverr == (pwdata == 0 || pwdata > 32'hFFFF)) else $error("Cycle range wrong");
	sleep_range_a: assert property (wr && paddr == SLEEP_OFS
		|-> pslverr == (pwdata == 0 || pwdata > 32'h15F900)) else $error("Sleep range wrong");
	wake_range_a: assert property (wr && paddr == WAKE_OFS
		|-> pslverr == (pwdata == 0 || pwdata > 32'h36EE80)) else $error("Wake range wrong");
	no_sleep_a: assert property (mode_q == MODE_NONE |=> awake && sleep_status)
		else $error("Slept in mode 0");
	pin_sleep_a: assert property (mode_q == MODE_PIN && sleep_request |=> !awake)
		else $error("Pin sleep ignored");
	pin_wake_a: assert property (mode_q == MODE_PIN && !sleep_request |=> awake)
		else $error("Pin wake ignored");
	asleep_low_a: assert property (!awake |-> !sleep_status && host_tx_hold)
		else $error("Outputs wrong while asleep");
	char_stop_a: assert property (serial_rx_char && awake |=> !host_tx_hold || !awake)
		else $error("Host delay not ended");
	discard_once_a: assert property (msg_discard && !msg_queued
		|=> !msg_discard && !msg_pending) else $error("Discard not single");
endmodule : sleep_wake_props

// [dv/host_wake_model.sv]
// Purpose: Host and wake circuitry driving the sleep request and serial lines.
// Assumes: Calls come from the bench; lines change just after pclk rises.
// Notes:   Lag lets the host answer promptly or slowly.
module host_wake_model (
	input  wire logic pclk,
	output logic      sleep_request,
	output logic      serial_rx_char
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		sleep_request = 1'b0;
		serial_rx_char = 1'b0;
	end
	task automatic hold_pin(input logic v);
		@(posedge pclk);
		sleep_request <= v;
	endtask : hold_pin
	task automatic send_char(input int lag);
		repeat (lag) @(posedge pclk);
		serial_rx_char <= 1'b1;
		@(posedge pclk);
		serial_rx_char <= 1'b0;
	endtask : send_char
endmodule : host_wake_model

// [dv/tb_sleep_wake_controller.sv]
// Purpose: Self-checking bench for the sleep and wake controller.
// Assumes: 1 ms shortened to 10 cycles, brief check window 2 ms.
// Notes:   Timer checks allow one tick of slack for the free-running tick.
module tb_sleep_wake_controller
	import sleep_wake_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic        msg_queued = 1'b0;
	logic        rf_activity = 1'b0;
	logic        msg_delivered = 1'b0;
	logic [31:0] prdata, r;
	logic        pready, pslverr, sleep_request, serial_rx_char, e;
	logic        sleep_status, awake, host_tx_hold, msg_pending, msg_discard;
	int          fails = 0, cmp_count = 0, cyc = 0, n, hi;
	logic [31:0] mreg [8] = '{32'h0, 32'h0, 32'h1, 32'hC8, 32'h7D0, 32'h0, 32'h0, 32'h18};
	logic [15:0] seed = 16'h0042;
	logic [39:0] wtab [14] = '{40'h0000000002, 40'h0000000003, 40'h0000000006,
		40'h0000000005, 40'h0400000001, 40'h0400000100, 40'h0800000000, 40'h0C00000000,
		40'h0C0015F901, 40'h0C0015F900, 40'h100036EE81, 40'h100036EE80, 40'h1C00000000,
		40'h2000000000};
	sleep_wake_controller #(.MS_TICK_CYCLES(10), .BRIEF_MS(2)) u_sleep_wake_controller (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.sleep_request(sleep_request), .rf_activity(rf_activity),
		.serial_rx_char(serial_rx_char), .msg_queued(msg_queued),
		.msg_delivered(msg_delivered), .sleep_status(sleep_status),
		.awake(awake), .host_tx_hold(host_tx_hold), .msg_pending(msg_pending),
		.msg_discard(msg_discard));
	host_wake_model u_host (.pclk(pclk), .sleep_request(sleep_request),
		.serial_rx_char(serial_rx_char));
	always #5 pclk = ~pclk;
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr
	function automatic logic legal(input logic [7:0] a, input logic [31:0] v);
		case (a)
			MODE_OFS:  return v == 0 || v == 1 || v == 4 || v == 5;
			OPT_OFS:   return v == 0 || v == 32'h100;
			CYCLE_OFS: return v >= 1 && v <= 32'hFFFF;
			SLEEP_OFS: return v >= 1 && v <= 32'h15F900;
			WAKE_OFS:  return v >= 1 && v <= 32'h36EE80;
			HOST_OFS:  return v <= 32'hFFFF;
			CTRL_OFS:  return v <= 1;
			default:   return 1'b0;
		endcase
	endfunction : legal
	task automatic complete_run;
		$display("Counts: %0d compares, %0d mismatches", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : complete_run
	task automatic chk_reg(input logic [31:0] g, input logic [31:0] x);
		cmp_count++;
		if (g !== x)
		begin
			fails++;
			$display("Error %0t: read %h, expected %h", $time, g, x);
		end
	endtask : chk_reg
	task automatic chk_bit(input logic g, input logic x);
		cmp_count++;
		if (g !== x)
		begin
			fails++;
			$display("Error %0t: flag %b, expected %b", $time, g, x);
		end
	endtask : chk_bit
	task automatic chk_time(input int g, input int lo, input int up);
		cmp_count++;
		if (g < lo || g > up)
		begin
			fails++;
			$display("Error %0t: took %0d, expected %0d to %0d", $time, g, lo, up);
		end
	endtask : chk_time
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr_chk(input logic [7:0] a, input logic [31:0] v);
		apb(1'b1, a, v);
		chk_bit(e, !legal(a, v));
		if (legal(a, v))
			mreg[a[4:2]] = v;
	endtask : wr_chk
	task automatic rd_chk(input logic [7:0] a);
		apb(1'b0, a, 32'h0);
		chk_reg(r, mreg[a[4:2]]);
	endtask : rd_chk
	task automatic wait_awake(input logic v);
		n = 0;
		while (awake !== v && n < 1000)
		begin
			@(negedge pclk);
			n++;
		end
	endtask : wait_awake
	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			fails++;
			complete_run();
		end
	end
	initial
	begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 8; i++)
			rd_chk(8'(i * 4));
		for (int i = 0; i < 14; i++)
		begin
			wr_chk(wtab[i][39:32], wtab[i][31:0]);
			if (wtab[i][39:32] < 8'h1C)
				rd_chk(wtab[i][39:32]);
		end
		for (int i = 0; i < 6; i++)
		begin
			seed = lfsr(seed);
			wr_chk(i[0] ? HOST_OFS : CYCLE_OFS, {16'h0, seed});
			rd_chk(i[0] ? HOST_OFS : CYCLE_OFS);
		end
		$display("Test registers done");
		wr_chk(HOST_OFS, 32'd5);
		wr_chk(MODE_OFS, 32'h1);
		u_host.hold_pin(1'b1);
		wait_awake(1'b0);
		chk_time(n, 1, 3);
		chk_bit(sleep_status, 1'b0);
		u_host.hold_pin(1'b0);
		wait_awake(1'b1);
		chk_time(n, 1, 3);
		chk_bit(host_tx_hold, 1'b1);
		repeat (30) @(negedge pclk);
		chk_bit(host_tx_hold, 1'b1);
		u_host.send_char(3);
		@(negedge pclk);
		chk_bit(host_tx_hold, 1'b0);
		wr_chk(HOST_OFS, 32'h0);
		u_host.hold_pin(1'b1);
		wait_awake(1'b0);
		u_host.hold_pin(1'b0);
		wait_awake(1'b1);
		chk_bit(host_tx_hold, 1'b0);
		$display("Test pin sleep done");
		wr_chk(CYCLE_OFS, 32'h2);
		wr_chk(SLEEP_OFS, 32'h1);
		wr_chk(WAKE_OFS, 32'h3);
		wr_chk(OPT_OFS, 32'h0);
		wr_chk(MODE_OFS, 32'h4);
		hi = 0;
		wait_awake(1'b0);
		for (int i = 0; i < 4; i++)
		begin
			wait_awake(1'b1);
			chk_time(n, 89, 102);
			hi += (sleep_status === 1'b1);
			wait_awake(1'b0);
			chk_time(n, 9, 22);
		end
		chk_time(hi, 2, 2);
		wait_awake(1'b1);
		@(posedge pclk) rf_activity <= 1'b1;
		@(posedge pclk) rf_activity <= 1'b0;
		wait_awake(1'b0);
		chk_time(n, 22, 31);
		wr_chk(OPT_OFS, 32'h100);
		wait_awake(1'b1);
		wait_awake(1'b0);
		chk_time(n, 19, 32);
		wr_chk(MODE_OFS, 32'h0);
		$display("Test cyclic done");
		wr_chk(CTRL_OFS, 32'h1);
		@(posedge pclk) msg_queued <= 1'b1;
		@(posedge pclk) msg_queued <= 1'b0;
		@(negedge pclk);
		chk_bit(msg_pending, 1'b1);
		n = 0;
		while (msg_discard !== 1'b1 && n < 400)
		begin
			@(negedge pclk);
			n++;
		end
		chk_time(n, 238, 251);
		@(posedge pclk) msg_queued <= 1'b1;
		@(posedge pclk) msg_queued <= 1'b0;
		repeat (20) @(posedge pclk);
		msg_delivered <= 1'b1;
		@(posedge pclk) msg_delivered <= 1'b0;
		@(negedge pclk);
		chk_bit(msg_pending, 1'b0);
		$display("Test message hold done");
		complete_run();
	end
endmodule : tb_sleep_wake_controller
bind sleep_wake_controller sleep_wake_props u_props (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .sleep_request(sleep_request),
	.rf_activity(rf_activity), .serial_rx_char(serial_rx_char), .msg_queued(msg_queued),
	.msg_delivered(msg_delivered), .sleep_status(sleep_status), .awake(awake),
	.host_tx_hold(host_tx_hold), .msg_pending(msg_pending), .msg_discard(msg_discard));
